// *** hw/sfi_defs.svh ***
// Constants for the serial flash interface state block
// Functional notes
// RL1: Chip select high holds standby; falling chip select starts instruction capture.
// RL2: Eight instruction bits captured MSB first, one per rising serial clock.
// RL3: Program guard sampled only in instruction cycles of register_write_cmd.
// RL4: Decoded instruction selects address space and transfer format for the command.
// RL5: Host raises chip select after eighth bit of stand-alone commands.
// RL6: Quad enable clear makes line3 the pause input; set makes it data.
// RL7: Pause low with chip select low freezes command, outputs go high impedance.
// RL8: Pause release resumes in the exact state held before the pause.
// RL9: DDR commands ignore pause and program guard.
// RL10: Single input leaves serial_out undriven; dual/quad output reads address on serial_in.
// RL11: Latency cycle count comes from two-bit latency code of config_reg.
// RL12: Latency cycles discard data lines and drive nothing.
// RL13: Host releases data lines by falling edge ending last latency cycle.
// RL14: Single output drives serial_out, ignores serial_in, repeats until chip select high.
// RL15: Dual I/O read takes two bits per clock, then latency or dual output.
// RL16: Dual output drives two bits per clock until chip select high.
// RL17: quad_page_write and quad_output_read_cmd take address on line0 only.
// RL18: After address, page write enters quad input; quad read latency or output.
// RL19: Quad input takes four bits per clock for address, mode or program data.
// RL20: Host raises chip select after program data, returning to standby.
// RL21: Host holds reset high, chip select low, pause high in single input.
// RL22: Quad output drives four bits per clock until chip select high.
// RL23: Quad mode must be enabled before DDR quad I/O reads are accepted.
// RL24: Sample host lines on rising clock, launch output on falling clock.
`ifndef SFI_DEFS_SVH
`define SFI_DEFS_SVH
`define SFI_CFG_OFS 5'h00
`define SFI_TX_OFS 5'h04
`define SFI_STAT_OFS 5'h08
`define SFI_ADDR_OFS 5'h0C
`define SFI_RX_OFS 5'h10
`define SFI_CFG_RST 32'h00000000
`define SFI_CFG_MASK 32'h000000C2
`define SFI_TX_RST 32'h00000000
`define SFI_QE_BIT 1
`define SFI_LAT_HI 7
`define SFI_LAT_LO 6
`define SFI_RESP_OK 2'h0
`define SFI_RESP_ERR 2'h2
`define SFI_OP_REGWR 8'h01
`define SFI_OP_NOP 8'h06
`define SFI_OP_READ 8'h03
`define SFI_OP_FAST 8'h0B
`define SFI_OP_DOR 8'h3B
`define SFI_OP_QOR 8'h6B
`define SFI_OP_DIO 8'hBB
`define SFI_OP_QIO 8'hEB
`define SFI_OP_QPW 8'h32
`define SFI_OP_DDR1 8'h0D
`define SFI_OP_DDR2 8'hBD
`define SFI_OP_DDR4 8'hED
`define SFI_W0 3'h0
`define SFI_W1 3'h1
`define SFI_W2 3'h2
`define SFI_W4 3'h4
`define SFI_INSTR_LAST 3'h7
`define SFI_ADDR_BITS 6'h18
`define SFI_AMODE_BITS 6'h20
`define SFI_NO_BITS 6'h00
`endif

// *** hw/sfi_pkg.sv ***
// Types of the serial flash interface state block
package sfi_pkg;
  typedef enum logic [3:0] {
    st_standby, st_instr, st_in, st_lat, st_out, st_ddr, st_done
  } sfi_state_t;
  typedef struct packed {
    logic known;
    logic rd;
    logic ddr;
    logic quad;
    logic lat;
    logic [2:0] aw;
    logic [2:0] ow;
    logic [2:0] dw;
    logic [5:0] abits;
  } sfi_cmd_t;
endpackage : sfi_pkg

// *** hw/sfi_top.sv ***
// Serial flash interface state sequencer with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "sfi_defs.svh"
module sfi_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash pins
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic [3:0] line_i,
  output logic [3:0] line_o,
  output logic [3:0] line_oe
);
  sfi_pkg::sfi_state_t state_q;
  sfi_pkg::sfi_cmd_t cmd_w;
  logic [5:0] s1_q, s2_q;
  logic sck_d_q;
  logic [31:0] cfg_q, tx_q, rx_q, addr_q, out_sr_q;
  logic [7:0] instr_sr_q, instr_q;
  logic [2:0] bit_cnt_q, aw_q, ow_q, dw_q;
  logic [5:0] bits_left_q;
  logic [3:0] lat_cnt_q;
  logic rd_q, guard_q, started_q;
  logic [4:0] aw_addr_q;
  logic aw_hold_q, w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] rx_d;
  logic [7:0] ib;
  logic cs_n_s, sck_s, pause_act, rise, fall, qe;
  logic [3:0] lin;

  function automatic sfi_pkg::sfi_cmd_t decode(input logic [7:0] op);
    sfi_pkg::sfi_cmd_t c;
    c = '0;
    c.known = 1'h1;
    case (op)
      `SFI_OP_REGWR:
      begin
        c.dw = `SFI_W1;
      end
      `SFI_OP_NOP: c.abits = `SFI_NO_BITS;
      `SFI_OP_READ:
      begin
        c = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, `SFI_W1, `SFI_W1, `SFI_W0, `SFI_ADDR_BITS};
      end
      `SFI_OP_FAST:
      begin
        c = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, `SFI_W1, `SFI_W1, `SFI_W0, `SFI_ADDR_BITS};
      end
      `SFI_OP_DOR:
      begin
        c = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, `SFI_W1, `SFI_W2, `SFI_W0, `SFI_ADDR_BITS};
      end
      `SFI_OP_QOR:
      begin
        c = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, `SFI_W1, `SFI_W4, `SFI_W0, `SFI_ADDR_BITS};
      end
      `SFI_OP_DIO:
      begin
        c = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, `SFI_W2, `SFI_W2, `SFI_W0, `SFI_AMODE_BITS};
      end
      `SFI_OP_QIO:
      begin
        c = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, `SFI_W4, `SFI_W4, `SFI_W0, `SFI_AMODE_BITS};
      end
      `SFI_OP_QPW:
      begin
        c = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, `SFI_W1, `SFI_W0, `SFI_W4, `SFI_ADDR_BITS};
      end
      `SFI_OP_DDR1, `SFI_OP_DDR2: c.ddr = 1'h1;
      `SFI_OP_DDR4:
      begin
        c.ddr = 1'h1;
        c.quad = 1'h1;
      end
      default: c.known = 1'h0;
    endcase
    return c;
  endfunction : decode

  function automatic logic [31:0] shift_in(input logic [31:0] sr, input logic [3:0] l,
                                           input logic [2:0] w);
    case (w)
      `SFI_W1: return {sr[30:0], l[0]};
      `SFI_W2: return {sr[29:0], l[1:0]};
      `SFI_W4: return {sr[27:0], l};
      default: return sr;
    endcase
  endfunction : shift_in

  function automatic logic [31:0] rotate(input logic [31:0] sr, input logic [2:0] w);
    case (w)
      `SFI_W1: return {sr[30:0], sr[31]};
      `SFI_W2: return {sr[29:0], sr[31:30]};
      `SFI_W4: return {sr[27:0], sr[31:28]};
      default: return sr;
    endcase
  endfunction : rotate

  function automatic logic [3:0] drive_bits(input logic [31:0] sr, input logic [2:0] w);
    case (w)
      `SFI_W1: return {2'h0, sr[31], 1'h0};
      `SFI_W2: return {2'h0, sr[31:30]};
      `SFI_W4: return sr[31:28];
      default: return 4'h0;
    endcase
  endfunction : drive_bits

  function automatic logic [3:0] lane_mask(input logic [2:0] w);
    case (w)
      `SFI_W1: return 4'h2;
      `SFI_W2: return 4'h3;
      `SFI_W4: return 4'hF;
      default: return 4'h0;
    endcase
  endfunction : lane_mask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Pin synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Clock bit resets to its idle low level so no false edge follows reset
      s1_q <= 6'h2F;
      s2_q <= 6'h2F;
      sck_d_q <= 1'h0;
    end
    else
    begin
      s1_q <= {chip_select_n, serial_clk, line_i};
      s2_q <= s1_q;
      sck_d_q <= s2_q[4];
    end
  end

  assign cs_n_s = s2_q[5];
  assign sck_s = s2_q[4];
  assign lin = s2_q[3:0];
  assign qe = cfg_q[`SFI_QE_BIT];
  // Pause only when line3 is not data and not in a DDR command
  assign pause_act = !qe && !lin[3] && !cs_n_s && state_q != sfi_pkg::st_ddr
                     && state_q != sfi_pkg::st_standby; // RL6 RL9
  assign rise = sck_s && !sck_d_q && !pause_act; // RL7 RL8 RL24
  assign fall = !sck_s && sck_d_q && !pause_act; // RL7 RL24
  assign ib = {instr_sr_q[6:0], lin[0]};
  assign cmd_w = decode(ib);
  assign rx_d = shift_in(rx_q, lin, (bits_left_q != `SFI_NO_BITS) ? aw_q : dw_q);

  // Interface state sequencing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= sfi_pkg::st_standby;
      bit_cnt_q <= 3'h0;
      instr_sr_q <= 8'h00;
      instr_q <= 8'h00;
      guard_q <= 1'h1;
      aw_q <= `SFI_W0;
      ow_q <= `SFI_W0;
      dw_q <= `SFI_W0;
      rd_q <= 1'h0;
      bits_left_q <= `SFI_NO_BITS;
      lat_cnt_q <= 4'h0;
      rx_q <= 32'h00000000;
      addr_q <= 32'h00000000;
    end
    else if (cs_n_s)
    begin
      state_q <= sfi_pkg::st_standby; // RL1 RL5 RL20
    end
    else
    begin
      case (state_q)
        sfi_pkg::st_standby:
        begin
          state_q <= sfi_pkg::st_instr; // RL1
          bit_cnt_q <= 3'h0;
        end
        sfi_pkg::st_instr:
        begin
          if (rise)
          begin
            instr_sr_q <= ib; // RL2
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == `SFI_INSTR_LAST)
            begin
              instr_q <= ib;
              aw_q <= cmd_w.aw; // RL4
              ow_q <= cmd_w.ow;
              dw_q <= cmd_w.dw;
              rd_q <= cmd_w.rd;
              bits_left_q <= cmd_w.abits;
              lat_cnt_q <= cmd_w.lat ? {2'h0, cfg_q[`SFI_LAT_HI:`SFI_LAT_LO]} : 4'h0; // RL11
              if (ib == `SFI_OP_REGWR)
              begin
                guard_q <= lin[2]; // RL3
              end
              if (!cmd_w.known || (cmd_w.quad && !qe)) // RL23
              begin
                state_q <= sfi_pkg::st_done;
              end
              else if (cmd_w.ddr)
              begin
                state_q <= sfi_pkg::st_ddr; // RL9
              end
              else if (ib == `SFI_OP_REGWR && !lin[2])
              begin
                state_q <= sfi_pkg::st_done; // RL3
              end
              else if (cmd_w.abits == `SFI_NO_BITS && cmd_w.dw == `SFI_W0)
              begin
                state_q <= sfi_pkg::st_done; // RL5
              end
              else
              begin
                state_q <= sfi_pkg::st_in; // RL10 RL17
              end
            end
          end
        end
        sfi_pkg::st_in:
        begin
          if (rise)
          begin
            rx_q <= rx_d; // RL15 RL17 RL19
            if (bits_left_q != `SFI_NO_BITS)
            begin
              bits_left_q <= bits_left_q - {3'h0, aw_q};
              if (bits_left_q == {3'h0, aw_q})
              begin
                addr_q <= rx_d;
                if (rd_q && lat_cnt_q == 4'h0)
                begin
                  state_q <= sfi_pkg::st_out; // RL15 RL18
                end
                else if (rd_q)
                begin
                  state_q <= sfi_pkg::st_lat; // RL15 RL18
                end
              end
            end
          end
        end
        sfi_pkg::st_lat:
        begin
          if (rise)
          begin
            lat_cnt_q <= lat_cnt_q - 4'h1; // RL12
            if (lat_cnt_q == 4'h1)
            begin
              state_q <= sfi_pkg::st_out;
            end
          end
        end
        sfi_pkg::st_out, sfi_pkg::st_ddr, sfi_pkg::st_done: state_q <= state_q;
        default: state_q <= sfi_pkg::st_standby;
      endcase
    end
  end

  // Output launch on falling clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_sr_q <= 32'h00000000;
      started_q <= 1'h0;
      line_o <= 4'h0;
      line_oe <= 4'h0;
    end
    else
    begin
      if (state_q != sfi_pkg::st_out)
      begin
        out_sr_q <= tx_q;
        started_q <= 1'h0;
      end
      else if (fall)
      begin
        started_q <= 1'h1;
        line_o <= drive_bits(out_sr_q, ow_q); // RL14 RL16 RL22
        out_sr_q <= rotate(out_sr_q, ow_q);
      end
      if (state_q == sfi_pkg::st_out && (started_q || fall) && !pause_act && !cs_n_s)
      begin
        line_oe <= lane_mask(ow_q); // RL14 RL16 RL22
      end
      else
      begin
        line_oe <= 4'h0; // RL7 RL10 RL12
      end
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'h0;
      s_axi_wready <= 1'h0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `SFI_RESP_OK;
      aw_hold_q <= 1'h0;
      w_hold_q <= 1'h0;
      aw_addr_q <= 5'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      cfg_q <= `SFI_CFG_RST;
      tx_q <= `SFI_TX_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'h0;
        aw_hold_q <= 1'h1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (!aw_hold_q && !s_axi_bvalid && !s_axi_awready)
      begin
        s_axi_awready <= 1'h1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'h0;
        w_hold_q <= 1'h1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (!w_hold_q && !s_axi_bvalid && !s_axi_wready)
      begin
        s_axi_wready <= 1'h1;
      end
      if (aw_hold_q && w_hold_q && !s_axi_bvalid)
      begin
        aw_hold_q <= 1'h0;
        w_hold_q <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= `SFI_RESP_OK;
        case (aw_addr_q)
          `SFI_CFG_OFS: cfg_q <= merge(cfg_q, w_data_q, w_strb_q) & `SFI_CFG_MASK;
          `SFI_TX_OFS: tx_q <= merge(tx_q, w_data_q, w_strb_q);
          default: s_axi_bresp <= `SFI_RESP_ERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'h0;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SFI_RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h1;
      s_axi_rresp <= `SFI_RESP_OK;
      case (s_axi_araddr)
        `SFI_CFG_OFS: s_axi_rdata <= cfg_q;
        `SFI_TX_OFS: s_axi_rdata <= tx_q;
        `SFI_STAT_OFS: s_axi_rdata <= {16'h0000, instr_q, 3'h0, guard_q, state_q};
        `SFI_ADDR_OFS: s_axi_rdata <= addr_q;
        `SFI_RX_OFS: s_axi_rdata <= rx_q;
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SFI_RESP_ERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'h0;
    end
    else if (!s_axi_rvalid && !s_axi_arready)
    begin
      s_axi_arready <= 1'h1;
    end
  end

  sequence cs_fall_s;
    state_q == sfi_pkg::st_standby && !cs_n_s;
  endsequence
  sequence last_instr_s;
    state_q == sfi_pkg::st_instr && rise && bit_cnt_q == `SFI_INSTR_LAST && !cs_n_s;
  endsequence
  property out_drive_p(logic [2:0] w, logic [3:0] m);
    @(posedge aclk) disable iff (!aresetn)
      state_q == sfi_pkg::st_out && ow_q == w && fall && !pause_act && !cs_n_s
      |=> line_oe == m;
  endproperty

  instr_enter_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
    cs_fall_s |=> state_q == sfi_pkg::st_instr) else $error("no instruction state");
  standby_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
    cs_n_s [*2] |-> line_oe == 4'h0 && state_q == sfi_pkg::st_standby)
    else $error("driving in standby");
  instr_len_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
    last_instr_s |=> state_q != sfi_pkg::st_instr) else $error("instruction not 8 bits");
  guard_when_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
    $changed(guard_q) |-> $past(state_q == sfi_pkg::st_instr && rise)
    && $past(instr_sr_q[6:0]) == `SFI_OP_REGWR >> 1) else $error("guard sampled late");
  hold_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL7 RL8
    pause_act && !cs_n_s |=> $stable(state_q) && $stable(bits_left_q) && $stable(lat_cnt_q))
    else $error("state moved in pause");
  hold_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
    pause_act |=> line_oe == 4'h0) else $error("driving in pause");
  ddr_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
    state_q == sfi_pkg::st_ddr && !cs_n_s |=> state_q == sfi_pkg::st_ddr)
    else $error("ddr left early");
  lat_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
    state_q == sfi_pkg::st_lat && $past(state_q) == sfi_pkg::st_lat |-> line_oe == 4'h0)
    else $error("driving in latency");
  in_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
    state_q == sfi_pkg::st_in [*2] |-> line_oe == 4'h0) else $error("driving in input");
  quad_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL23
    last_instr_s ##0 (cmd_w.quad && !qe) |=> state_q == sfi_pkg::st_done)
    else $error("quad command without quad mode");
  single_out_a: assert property (out_drive_p(`SFI_W1, 4'h2)) // RL14
    else $error("single output lanes wrong");
  dual_out_a: assert property (out_drive_p(`SFI_W2, 4'h3)) // RL16
    else $error("dual output lanes wrong");
  quad_out_a: assert property (out_drive_p(`SFI_W4, 4'hF)) // RL22
    else $error("quad output lanes wrong");
endmodule : sfi_top

// *** sim/sfi_host_model.sv ***
// Host serial controller model: chip select, serial clock and lane drive
`timescale 1ns/100ps
module sfi_host_model (
  // Clock
  input wire logic aclk,
  // Flash pins
  output logic chip_select_n,
  output logic serial_clk,
  output logic [3:0] host_v,
  output logic [3:0] host_oe,
  input wire logic [3:0] line_lvl
);
  initial
  begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    host_v = 4'h0;
    host_oe = 4'h0;
  end
  task automatic half();
    repeat (4) @(posedge aclk);
  endtask : half
  // Select with clock low
  task automatic start();
    chip_select_n <= 1'b0;
    half();
  endtask : start
  // Clock stays low outside frames
  task automatic stop();
    chip_select_n <= 1'b1;
    host_oe <= 4'h0;
    half();
  endtask : stop
  // Lanes set in low phase, read back late in high phase
  task automatic cyc(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] g);
    host_v <= v;
    host_oe <= oe;
    half();
    serial_clk <= 1'b1;
    half();
    g = line_lvl;
    serial_clk <= 1'b0;
  endtask : cyc
endmodule : sfi_host_model

// *** sim/sfi_top_test.sv ***
// Self-checking bench for the serial flash interface state block
`timescale 1ns/100ps
`define SFI_CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("unexpected at %0t: got %h want %h", $time, g, e); \
    end \
  end
module sfi_top_test;
  typedef struct packed {logic [33:0] v; logic [33:0] m;} sfi_exp_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, chip_select_n, serial_clk, flt_q, res_v, guard, qe;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, res_d, q_acc;
  logic [3:0] s_axi_wstrb, line_i, line_o, line_oe, host_v, host_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errors, check_count;
  int seed = 11207;
  sfi_exp_t exp_q[$];
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) flt_q <= ~flt_q;
  // Released lanes float to a toggling level
  assign line_i = (line_oe & line_o) | (~line_oe & host_oe & host_v) |
    (~line_oe & ~host_oe & {4{flt_q}});
  sfi_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_select_n,
    .serial_clk, .line_i, .line_o, .line_oe);
  sfi_host_model host (.aclk, .chip_select_n, .serial_clk, .host_v, .host_oe,
    .line_lvl(line_i));
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic timeout();
    errors++;
    $display("unexpected at %0t: wait ran out", $time);
    final_report();
  endtask : timeout
  task automatic expect_val(input logic [33:0] v, input logic [33:0] m);
    exp_q.push_back({v, m});
  endtask : expect_val
  task automatic take(input logic [33:0] g);
    sfi_exp_t e;
    if (exp_q.size() == 0)
    begin
      errors++;
      $display("unexpected at %0t: result without note", $time);
    end
    else
    begin
      e = exp_q.pop_front();
      `SFI_CHK(g & e.m, e.v & e.m)
    end
  endtask : take
  // Result watcher
  always @(posedge aclk)
  begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) take({s_axi_bresp, 32'h0});
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) take({s_axi_rresp, s_axi_rdata});
    if (res_v === 1'b1) take({2'h0, res_d});
  end
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    expect_val({r, 32'h0}, {2'h3, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) timeout();
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [4:0] a, input logic [31:0] v, input logic [31:0] m,
      input logic [1:0] r);
    int n;
    expect_val({r, v}, {2'h3, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) timeout();
    @(posedge aclk);
  endtask : axi_rd
  // Serial cycles; host holds pause high while not in quad mode and drives guard on line2 from the guard flag in single-width cycles except quad-mode reads
  task automatic xfer(input int n, input int w, input bit rx, input bit idle,
      input logic [31:0] d);
    logic [3:0] v, oe, g;
    for (int i = 0; i < n; i++)
    begin
      v = w == 4 ? d[31:28] : w == 2 ? {2'h3, d[31:30]} : {1'b1, guard, 1'b0, d[31]};
      oe = w == 1 ? 4'hD : 4'hF;
      if (rx) oe = (w == 4 || qe) ? 4'h0 : 4'hC;
      d = d << w;
      host.cyc(v, oe, g);
      q_acc = (q_acc << w) | (w == 4 ? 32'(g) : w == 2 ? 32'(g[1:0]) : 32'(g[1]));
      if (idle) `SFI_CHK(line_oe, 4'h0)
    end
  endtask : xfer
  task automatic rd_cmd(input logic [7:0] op, input int aw, input int ab, input int lat,
      input int ow, input logic [31:0] tx, input bit pz);
    logic [3:0] g;
    host.start();
    xfer(8, 1, 0, 1, {op, 24'h0});
    xfer(ab / aw / 2, aw, 0, 1, $random(seed));
    // Clock keeps running while paused
    for (int i = 0; i < 3 && pz; i++)
    begin
      host.cyc(4'h5, 4'hD, g);
      `SFI_CHK(line_oe, 4'h0)
    end
    xfer(ab / aw / 2, aw, 0, 1, $random(seed));
    xfer(lat, ow, 1, 1, 32'h0);
    q_acc = 32'h0;
    xfer(32 / ow, ow, 1, 0, 32'h0);
    expect_val({2'h0, tx}, 34'h3FFFFFFFF);
    res_d <= q_acc;
    res_v <= 1'b1;
    @(posedge aclk);
    res_v <= 1'b0;
    host.stop();
    axi_rd(5'h08, 32'h0, 32'hF, 2'h0);
    $display("read %h done", op);
  endtask : rd_cmd
  initial
  begin
    logic [7:0] ops[6] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB};
    int aws[6] = '{1, 1, 1, 1, 2, 4};
    int abs[6] = '{24, 24, 24, 24, 32, 32};
    int ows[6] = '{1, 1, 2, 4, 2, 4};
    logic [7:0] bad[9] = '{8'h06, 8'h6B, 8'hEB, 8'h32, 8'hED, 8'h0D, 8'hBD, 8'h01, 8'hED};
    logic [3:0] bst[9] = '{4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h5, 4'h5, 4'h6, 4'h5};
    logic [31:0] tx;
    logic [1:0] lat;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, res_v, res_d, q_acc} = '0;
    {aresetn, flt_q, guard, qe, errors, check_count} = '0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi_rd(5'h00, 32'h0, 32'hFFFFFFFF, 2'h0);
    axi_rd(5'h04, 32'h0, 32'hFFFFFFFF, 2'h0);
    axi_rd(5'h08, 32'h0, 32'hF, 2'h0);
    axi_rd(5'h14, 32'h0, 32'hFFFFFFFF, 2'h2);
    axi_wr(5'h14, 32'h1, 2'h2);
    axi_wr(5'h08, 32'h1, 2'h2);
    axi_wr(5'h00, 32'hFFFFFFFF, 2'h0);
    axi_rd(5'h00, 32'hC2, 32'hFFFFFFFF, 2'h0);
    $display("register test done");
    for (int p = 0; p < 2; p++)
      for (int k = 0; k < 6; k++)
      begin
        lat = 2'($random(seed));
        tx = $random(seed);
        qe = p[0];
        guard = p[0];
        axi_wr(5'h00, {24'h0, lat, 4'h0, qe, 1'b0}, 2'h0);
        axi_wr(5'h04, tx, 2'h0);
        if (ows[k] != 4 || qe) rd_cmd(ops[k], aws[k], abs[k], k ? lat : 0, ows[k], tx, !qe);
      end
    guard = 1'b0;
    for (int k = 0; k < 9; k++)
    begin
      qe = (k == 8);
      axi_wr(5'h00, {30'h0, qe, 1'b0}, 2'h0);
      host.start();
      xfer(8, 1, 0, 1, {bad[k], 24'h0});
      axi_rd(5'h08, {28'h0, bst[k]}, 32'hF, 2'h0);
      xfer(8, 1, 0, 1, $random(seed));
      host.stop();
      axi_rd(5'h08, 32'h0, 32'hF, 2'h0);
    end
    $display("refusal test done");
    guard = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      tx = $random(seed);
      qe = k[0];
      axi_wr(5'h00, {30'h0, qe, 1'b0}, 2'h0);
      host.start();
      xfer(8, 1, 0, 1, {k ? 8'h32 : 8'h01, 24'h0});
      if (k) xfer(24, 1, 0, 1, $random(seed));
      xfer(k ? 8 : 32, k ? 4 : 1, 0, 1, tx);
      host.stop();
      axi_rd(5'h10, tx, 32'hFFFFFFFF, 2'h0);
      axi_rd(5'h08, 32'h0, 32'hF, 2'h0);
    end
    $display("write test done");
    repeat (4) @(posedge aclk);
    if (exp_q.size() != 0) timeout();
    final_report();
  end
endmodule : sfi_top_test
